// File: core/diag_monitor_defines.vh
// constants for the diagnostics and monitor block
`ifndef DIAG_MONITOR_DEFINES_VH
`define DIAG_MONITOR_DEFINES_VH
`define IDX_OUTPUT_MODE 16'h3010
`define IDX_OUTPUT_CEILING 16'h3011
`define IDX_FILTER_COEFF 16'h3023
`define IDX_STORE_PARAMS 16'h1010
`define IDX_HEATSINK_TEMPERATURE 16'h3110
`define IDX_BATTERY_VOLTAGE 16'h3120
`define IDX_DRIVER_CURRENT_ARRAY 16'h3130
`define IDX_DRIVER_DUTY_ARRAY 16'h3131
`define IDX_OPERATING_HOURS 16'h3140
`define PARAM_RANGE_HI 8'h30
`define MONITOR_RANGE_HI 8'h31
`define DRIVER_COUNT 8'h06
`define FILTER_COUNT 8'h02
`define FILTER_COEFF_MIN 16'h0001
`define FILTER_COEFF_MAX 16'h4000
`define FILTER_COEFF_RESET 16'h0040
`define BACKUP_COMMAND 32'h6B636162
`define TEMP_MIN -16'sd400
`define TEMP_MAX 16'sd1000
`define BATT_MAX 16'h04B0
`define CURRENT_MAX 16'h012C
`define DUTY_MAX 16'h03E8
`define EEPROM_FAULT_CODE 8'h12
`define LOG_DEPTH 16
`define FILTER_TICK_NS 3906250
`define CLOCK_NS 100
`define FLASH_ON_MS 250
`define FLASH_OFF_MS 250
`define GROUP_GAP_MS 1000
`define FAST_FLASH_MS 62
`define MS_NS 1000000
`endif

// File: core/diag_monitor.v
// diagnostics, monitor objects, fault log, lamp coding and filter block
//
// What this block does
// - Writing output mode forces output ceiling to minimum and driver command to zero.
// - Output ceiling unit follows the low two bits of the newly written output mode; the ceiling value is not range-limited.
// - Analog smoothing is first order; time constant halves as coefficient doubles.
// - Filter reaches 63% in one time constant, full after five.
// - Monitor objects at 3100h, read/write, except array length sub-index read-only.
// - Heatsink temperature in tenths of a degree, -400 to 1000.
// - Battery voltage in tenths of a volt, 0 to 1200.
// - Driver current array length 6; entries hundredths of ampere, 0 to 300.
// - Driver duty array entries in tenths of percent, 0 to 1000.
// - Operating hours read as unsigned 0 to 65535.
// - New fault sends one emergency message, never repeated.
// - Fault clearing sends a no-fault emergency message.
// - Each new fault logs code and hours into a 16-entry FIFO.
// - Highest fault flashed: red place, yellow digit, repeated for both digits.
// - Without fault the yellow lamp flashes continuously.
// - Power-up program check; on mismatch the red lamp flashes rapidly.
// - Normal-block storage fault 12 clears on any SDO write in 3000h range.
// - Backup-block storage fault clears on backup store command write.
// - Smoothing coefficient is an array per analog input, values 1 to 16384.
`timescale 1ns/1ns
`default_nettype none
`include "diag_monitor_defines.vh"
module diag_monitor #(
  parameter integer FILTER_TICK_CYCLES = `FILTER_TICK_NS / `CLOCK_NS,
  parameter integer FLASH_ON_CYCLES = `FLASH_ON_MS * (`MS_NS / `CLOCK_NS),
  parameter integer FLASH_OFF_CYCLES = `FLASH_OFF_MS * (`MS_NS / `CLOCK_NS),
  parameter integer GROUP_GAP_CYCLES = `GROUP_GAP_MS * (`MS_NS / `CLOCK_NS),
  parameter integer FAST_FLASH_CYCLES = `FAST_FLASH_MS * (`MS_NS / `CLOCK_NS)
) (
  input wire sys_clk,
  input wire rst,
  input wire sdo_write,
  input wire sdo_read,
  input wire [15:0] sdo_index,
  input wire [7:0] sdo_subindex,
  input wire [31:0] sdo_wdata,
  output reg [31:0] sdo_rdata,
  output reg sdo_ack,
  output reg sdo_abort,
  input wire command_receive_message,
  input wire [15:0] command_value,
  output reg [15:0] driver_command,
  output reg [2:0] output_mode,
  output reg [1:0] ceiling_unit,
  output reg [15:0] output_ceiling,
  input wire signed [15:0] temp_sample,
  input wire [15:0] batt_sample,
  input wire [95:0] current_samples,
  input wire [95:0] duty_samples,
  input wire [15:0] hours_sample,
  input wire [31:0] analog_samples,
  output wire [31:0] analog_filtered,
  input wire [7:0] fault_code,
  input wire code_check_done,
  input wire code_check_ok,
  input wire eeprom_fault_normal_set,
  input wire eeprom_fault_backup_set,
  output reg eeprom_fault_normal,
  output reg eeprom_fault_backup,
  output reg emcy_send,
  output reg [7:0] emcy_code,
  input wire [3:0] log_read_index,
  output reg [23:0] log_read_data,
  output reg [4:0] log_count,
  output reg red_lamp,
  output reg yellow_lamp
);
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_RED1 = 3'd1;
  localparam [2:0] S_YEL1 = 3'd2;
  localparam [2:0] S_RED2 = 3'd3;
  localparam [2:0] S_YEL2 = 3'd4;
  localparam [2:0] S_GAP = 3'd5;
  localparam [2:0] S_CORRUPT = 3'd6;

  // monitor object values, clamped to their object ranges
  reg signed [15:0] heatsink_temperature;
  reg [15:0] battery_voltage;
  reg [15:0] driver_current_array [0:5];
  reg [15:0] driver_duty_array [0:5];
  reg [15:0] operating_hours;
  reg [15:0] filter_coeff [0:1];
  reg [23:0] log_mem [0:`LOG_DEPTH-1];
  reg [3:0] log_wr;
  reg [7:0] last_code;
  reg [23:0] tick_cnt;
  wire filter_tick = (tick_cnt == FILTER_TICK_CYCLES - 1);
  wire in_param = sdo_index[15:8] == `PARAM_RANGE_HI;
  wire in_monitor = sdo_index[15:8] == `MONITOR_RANGE_HI;
  wire is_array = (sdo_index == `IDX_DRIVER_CURRENT_ARRAY) ||
    (sdo_index == `IDX_DRIVER_DUTY_ARRAY);
  wire sub_ok = (sdo_subindex >= 8'h01) && (sdo_subindex <= `DRIVER_COUNT);
  wire [2:0] sub_n = sdo_subindex[2:0] - 3'd1;
  integer i;

  always @(posedge sys_clk) begin
    if (rst) begin
      tick_cnt <= 24'h000000;
    end else if (filter_tick) begin
      tick_cnt <= 24'h000000;
    end else begin
      tick_cnt <= tick_cnt + 24'h000001;
    end
  end

  // sampling of monitor inputs with range clamps
  always @(posedge sys_clk) begin
    if (rst) begin
      heatsink_temperature <= 16'sh0000;
      battery_voltage <= 16'h0000;
      operating_hours <= 16'h0000;
      for (i = 0; i < 6; i = i + 1) begin
        driver_current_array[i] <= 16'h0000;
        driver_duty_array[i] <= 16'h0000;
      end
    end else begin
      heatsink_temperature <= (temp_sample < `TEMP_MIN) ? `TEMP_MIN :
        (temp_sample > `TEMP_MAX) ? `TEMP_MAX : temp_sample;
      battery_voltage <= (batt_sample > `BATT_MAX) ? `BATT_MAX : batt_sample;
      operating_hours <= hours_sample;
      for (i = 0; i < 6; i = i + 1) begin
        driver_current_array[i] <= (current_samples[i*16 +: 16] > `CURRENT_MAX) ?
          `CURRENT_MAX : current_samples[i*16 +: 16];
        driver_duty_array[i] <= (duty_samples[i*16 +: 16] > `DUTY_MAX) ?
          `DUTY_MAX : duty_samples[i*16 +: 16];
      end
    end
  end

  // one first-order filter per analog input: y += (x - y) * coeff / 2^14 per tick
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : filt
      reg [29:0] acc;
      wire [29:0] x_ext = {analog_samples[g*16 +: 16], 14'h0000};
      wire signed [31:0] diff = $signed({2'b00, x_ext[29:14]}) -
        $signed({2'b00, acc[29:14]}) ;
      wire signed [47:0] step = diff * $signed({1'b0, filter_coeff[g]});
      always @(posedge sys_clk) begin
        if (rst) begin
          acc <= 30'h00000000;
        end else if (filter_tick) begin
          acc <= acc + step[29:0];
        end
      end
      assign analog_filtered[g*16 +: 16] = acc[29:14];
    end
  endgenerate

  // SDO access: parameters, monitor reads and storage fault recovery
  always @(posedge sys_clk) begin
    if (rst) begin
      sdo_ack <= 1'b0;
      sdo_abort <= 1'b0;
      sdo_rdata <= 32'h00000000;
      output_mode <= 3'd0;
      ceiling_unit <= 2'd0;
      output_ceiling <= 16'h0000;
      driver_command <= 16'h0000;
      eeprom_fault_normal <= 1'b0;
      eeprom_fault_backup <= 1'b0;
      filter_coeff[0] <= `FILTER_COEFF_RESET;
      filter_coeff[1] <= `FILTER_COEFF_RESET;
    end else begin
      sdo_ack <= sdo_read | sdo_write;
      sdo_abort <= 1'b0;
      if (command_receive_message) begin
        driver_command <= command_value;
      end
      if (sdo_write && sdo_index == `IDX_OUTPUT_MODE) begin
        output_mode <= sdo_wdata[2:0];
        output_ceiling <= 16'h0000;
        driver_command <= 16'h0000;
        ceiling_unit <= (sdo_wdata[1:0] == 2'd0) ? 2'd0 : sdo_wdata[1:0];
      end
      if (sdo_write && sdo_index == `IDX_OUTPUT_CEILING) begin
        output_ceiling <= sdo_wdata[15:0];
      end
      if (sdo_write && sdo_index == `IDX_FILTER_COEFF) begin
        if (sdo_subindex >= 8'h01 && sdo_subindex <= `FILTER_COUNT &&
            sdo_wdata[15:0] >= `FILTER_COEFF_MIN &&
            sdo_wdata[15:0] <= `FILTER_COEFF_MAX && sdo_wdata[31:16] == 16'h0000) begin
          filter_coeff[sdo_subindex[1] ? 1 : 0] <= sdo_wdata[15:0];
        end else begin
          sdo_abort <= 1'b1;
        end
      end
      if (sdo_write && in_monitor && is_array && sdo_subindex == 8'h00) begin
        sdo_abort <= 1'b1;
      end
      // set wins over clear
      if (eeprom_fault_normal_set) begin
        eeprom_fault_normal <= 1'b1;
      end else if (sdo_write && in_param) begin
        eeprom_fault_normal <= 1'b0;
      end
      if (eeprom_fault_backup_set) begin
        eeprom_fault_backup <= 1'b1;
      end else if (sdo_write && sdo_index == `IDX_STORE_PARAMS &&
          sdo_wdata == `BACKUP_COMMAND) begin
        eeprom_fault_backup <= 1'b0;
      end
      if (sdo_read) begin
        sdo_rdata <= 32'h00000000;
        case (sdo_index)
          `IDX_HEATSINK_TEMPERATURE: sdo_rdata <= {{16{heatsink_temperature[15]}},
            heatsink_temperature};
          `IDX_BATTERY_VOLTAGE: sdo_rdata <= {16'h0000, battery_voltage};
          `IDX_OPERATING_HOURS: sdo_rdata <= {16'h0000, operating_hours};
          `IDX_DRIVER_CURRENT_ARRAY, `IDX_DRIVER_DUTY_ARRAY: begin
            if (sdo_subindex == 8'h00) begin
              sdo_rdata <= {24'h000000, `DRIVER_COUNT};
            end else if (sub_ok) begin
              sdo_rdata <= {16'h0000, sdo_index[0] ? driver_duty_array[sub_n] :
                driver_current_array[sub_n]};
            end else begin
              sdo_abort <= 1'b1;
            end
          end
          `IDX_FILTER_COEFF: begin
            if (sdo_subindex == 8'h00) begin
              sdo_rdata <= {24'h000000, `FILTER_COUNT};
            end else begin
              sdo_rdata <= {16'h0000, filter_coeff[sdo_subindex[1] ? 1 : 0]};
            end
          end
          `IDX_OUTPUT_MODE: sdo_rdata <= {29'h00000000, output_mode};
          `IDX_OUTPUT_CEILING: sdo_rdata <= {16'h0000, output_ceiling};
          default: sdo_abort <= 1'b1;
        endcase
      end
    end
  end

  // emergency messages and fault log
  always @(posedge sys_clk) begin
    if (rst) begin
      last_code <= 8'h00;
      emcy_send <= 1'b0;
      emcy_code <= 8'h00;
      log_wr <= 4'h0;
      log_count <= 5'd0;
      log_read_data <= 24'h000000;
    end else begin
      emcy_send <= 1'b0;
      last_code <= fault_code;
      log_read_data <= log_mem[log_read_index];
      if (fault_code != last_code) begin
        emcy_send <= 1'b1;
        emcy_code <= fault_code;
        if (fault_code != 8'h00) begin
          log_mem[log_wr] <= {fault_code, operating_hours};
          log_wr <= log_wr + 4'h1;
          if (log_count != 5'd16) begin
            log_count <= log_count + 5'd1;
          end
        end
      end
    end
  end

  // lamp flash coding
  reg [2:0] lamp_state;
  reg [3:0] flash_left;
  reg [24:0] lamp_cnt;
  reg lamp_on;
  reg [7:0] shown_code;
  reg check_failed;
  wire phase_end = lamp_on ? (lamp_cnt == FLASH_ON_CYCLES - 1) :
    (lamp_cnt == FLASH_OFF_CYCLES - 1);

  always @(posedge sys_clk) begin
    if (rst) begin
      lamp_state <= S_IDLE;
      flash_left <= 4'h0;
      lamp_cnt <= 25'd0;
      lamp_on <= 1'b0;
      shown_code <= 8'h00;
      check_failed <= 1'b0;
      red_lamp <= 1'b0;
      yellow_lamp <= 1'b0;
    end else begin
      lamp_cnt <= lamp_cnt + 25'd1;
      if (code_check_done && !code_check_ok) begin
        check_failed <= 1'b1;
        lamp_state <= S_CORRUPT;
      end
      case (lamp_state)
        S_CORRUPT: begin
          yellow_lamp <= 1'b0;
          if (lamp_cnt >= FAST_FLASH_CYCLES - 1) begin
            lamp_cnt <= 25'd0;
            red_lamp <= ~red_lamp;
          end
        end
        S_IDLE: begin
          red_lamp <= 1'b0;
          if (fault_code != 8'h00 && !check_failed) begin
            shown_code <= fault_code;
            flash_left <= 4'd1;
            lamp_state <= S_RED1;
            lamp_on <= 1'b1;
            lamp_cnt <= 25'd0;
            yellow_lamp <= 1'b0;
          end else if (phase_end) begin
            lamp_cnt <= 25'd0;
            lamp_on <= ~lamp_on;
            yellow_lamp <= ~lamp_on;
          end
        end
        S_GAP: begin
          red_lamp <= 1'b0;
          yellow_lamp <= 1'b0;
          if (lamp_cnt >= GROUP_GAP_CYCLES - 1) begin
            lamp_state <= S_IDLE;
            lamp_cnt <= 25'd0;
            lamp_on <= 1'b0;
          end
        end
        default: begin
          red_lamp <= lamp_on && (lamp_state == S_RED1 || lamp_state == S_RED2);
          yellow_lamp <= lamp_on && (lamp_state == S_YEL1 || lamp_state == S_YEL2);
          if (phase_end) begin
            lamp_cnt <= 25'd0;
            lamp_on <= ~lamp_on;
            if (!lamp_on) begin
              if (flash_left > 4'd1) begin
                flash_left <= flash_left - 4'd1;
              end else begin
                // next group: red place, yellow digit value
                case (lamp_state)
                  S_RED1: flash_left <= shown_code[7:4];
                  S_YEL1: flash_left <= 4'd2;
                  S_RED2: flash_left <= shown_code[3:0];
                  default: flash_left <= 4'd0;
                endcase
                lamp_state <= (lamp_state == S_YEL2) ? S_GAP : lamp_state + 3'd1;
                if (lamp_state != S_YEL2 && ((lamp_state == S_RED1 &&
                    shown_code[7:4] == 4'h0) || (lamp_state == S_RED2 &&
                    shown_code[3:0] == 4'h0))) begin
                  lamp_state <= lamp_state + 3'd1;
                  lamp_on <= 1'b0;
                  flash_left <= 4'd1;
                end
              end
            end
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: bench/diag_monitor_chk.sv
// assertion checker bound to the diagnostics monitor block
`timescale 1ns/1ns
`default_nettype none
`include "diag_monitor_defines.vh"
module diag_monitor_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sdo_write,
  input wire logic sdo_read,
  input wire logic [15:0] sdo_index,
  input wire logic [7:0] sdo_subindex,
  input wire logic [31:0] sdo_wdata,
  input wire logic sdo_ack,
  input wire logic sdo_abort,
  input wire logic [15:0] driver_command,
  input wire logic [15:0] output_ceiling,
  input wire logic [7:0] fault_code,
  input wire logic eeprom_fault_normal_set,
  input wire logic eeprom_fault_backup_set,
  input wire logic eeprom_fault_normal,
  input wire logic eeprom_fault_backup,
  input wire logic emcy_send,
  input wire logic [7:0] emcy_code,
  input wire logic [4:0] log_count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  sdo_ack_due_a: assert property ((sdo_read || sdo_write) |=> sdo_ack)
    else $error("request not acknowledged");
  length_ro_a: assert property ((sdo_write && sdo_subindex == 8'h00 &&
    (sdo_index == `IDX_DRIVER_CURRENT_ARRAY || sdo_index == `IDX_DRIVER_DUTY_ARRAY))
    |=> sdo_abort) else $error("length write not refused");
  mode_clears_a: assert property ((sdo_write && sdo_index == `IDX_OUTPUT_MODE) |=>
    (output_ceiling == 16'h0000 && driver_command == 16'h0000)) else $error("mode write kept output");
  emcy_on_change_a: assert property ($changed(fault_code) |=>
    (emcy_send && emcy_code == $past(fault_code))) else $error("emergency missing");
  emcy_once_a: assert property (emcy_send |->
    $past(fault_code) != $past(fault_code, 2)) else $error("emergency repeated");
  log_step_a: assert property ((emcy_send && emcy_code != 8'h00) |->
    log_count == (($past(log_count) == 5'h10) ? 5'h10 : $past(log_count) + 5'h01))
    else $error("log count wrong");
  normal_clear_a: assert property ((sdo_write && sdo_index[15:8] == `PARAM_RANGE_HI &&
    !eeprom_fault_normal_set) |=> !eeprom_fault_normal) else $error("normal fault kept");
  backup_clear_a: assert property ((sdo_write && sdo_index == `IDX_STORE_PARAMS &&
    sdo_wdata == `BACKUP_COMMAND && !eeprom_fault_backup_set) |=> !eeprom_fault_backup)
    else $error("backup fault kept");
endmodule
bind diag_monitor diag_monitor_chk chk (.sys_clk, .rst, .sdo_write, .sdo_read, .sdo_index,
  .sdo_subindex, .sdo_wdata, .sdo_ack, .sdo_abort, .driver_command, .output_ceiling, .fault_code,
  .eeprom_fault_normal_set, .eeprom_fault_backup_set, .eeprom_fault_normal, .eeprom_fault_backup,
  .emcy_send, .emcy_code, .log_count);
`default_nettype wire

// File: bench/canopen_master_model.sv
// behavioural bus master issuing sdo transfers and command messages
`timescale 1ns/1ns
`default_nettype none
module canopen_master_model (
  input wire logic sys_clk,
  input wire logic [31:0] sdo_rdata,
  input wire logic sdo_ack,
  input wire logic sdo_abort,
  output logic sdo_write,
  output logic sdo_read,
  output logic [15:0] sdo_index,
  output logic [7:0] sdo_subindex,
  output logic [31:0] sdo_wdata,
  output logic command_receive_message,
  output logic [15:0] command_value
);
  initial begin
    {sdo_write, sdo_read, command_receive_message} = 3'h0;
    {sdo_index, sdo_subindex, sdo_wdata, command_value} = 72'h0;
  end
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
    input logic [31:0] data, output logic [31:0] rd, output logic ab);
    int n;
    @(negedge sys_clk);
    sdo_write = wr;
    sdo_read = ~wr;
    sdo_index = idx;
    sdo_subindex = sub;
    sdo_wdata = data;
    @(negedge sys_clk);
    sdo_write = 1'b0;
    sdo_read = 1'b0;
    sdo_wdata = ~data;
    n = 0;
    while (sdo_ack !== 1'b1 && n < 4) begin
      @(negedge sys_clk);
      n++;
    end
    rd = (n < 4) ? sdo_rdata : 32'hXXXXXXXX;
    ab = (n < 4) ? sdo_abort : 1'bx;
  endtask
  // ceiling is rewritten by the caller before this restores the command
  task automatic send_command(input logic [15:0] v);
    @(negedge sys_clk);
    command_receive_message = 1'b1;
    command_value = v;
    @(negedge sys_clk);
    command_receive_message = 1'b0;
    command_value = ~v;
  endtask
endmodule
`default_nettype wire

// File: bench/tb.sv
// self-checking bench for the diagnostics monitor block
`timescale 1ns/1ns
`default_nettype none
`include "diag_monitor_defines.vh"
module tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic sdo_write, sdo_read, sdo_ack, sdo_abort, command_receive_message, ab;
  logic [15:0] sdo_index, command_value, driver_command, output_ceiling;
  logic [15:0] temp_sample = 16'hFE70;
  logic [15:0] batt_sample = 16'h04B0;
  logic [15:0] hours_sample = 16'hFFFF;
  logic [95:0] current_samples = 96'h0;
  logic [95:0] duty_samples = 96'h0;
  logic [31:0] analog_samples = 32'h0;
  logic [7:0] fault_code = 8'h00;
  logic [3:0] log_read_index = 4'h0;
  logic code_check_done = 1'b1;
  logic code_check_ok = 1'b1;
  logic eeprom_fault_normal_set = 1'b0;
  logic eeprom_fault_backup_set = 1'b0;
  logic [7:0] sdo_subindex, emcy_code;
  logic [31:0] sdo_wdata, sdo_rdata, analog_filtered, rd;
  logic [2:0] output_mode;
  logic [1:0] ceiling_unit;
  logic eeprom_fault_normal, eeprom_fault_backup, emcy_send, red_lamp, yellow_lamp;
  logic [23:0] log_read_data;
  logic [4:0] log_count;
  string s;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  always #50 sys_clk = ~sys_clk;
  diag_monitor #(.FILTER_TICK_CYCLES(10), .FLASH_ON_CYCLES(4), .FLASH_OFF_CYCLES(4),
    .GROUP_GAP_CYCLES(12), .FAST_FLASH_CYCLES(2)) uut (.sys_clk, .rst, .sdo_write, .sdo_read,
    .sdo_index, .sdo_subindex, .sdo_wdata, .sdo_rdata, .sdo_ack, .sdo_abort,
    .command_receive_message, .command_value, .driver_command, .output_mode, .ceiling_unit,
    .output_ceiling, .temp_sample, .batt_sample, .current_samples, .duty_samples,
    .hours_sample, .analog_samples, .analog_filtered, .fault_code, .code_check_done,
    .code_check_ok, .eeprom_fault_normal_set, .eeprom_fault_backup_set, .eeprom_fault_normal,
    .eeprom_fault_backup, .emcy_send, .emcy_code, .log_read_index, .log_read_data, .log_count,
    .red_lamp, .yellow_lamp);
  canopen_master_model master (.sys_clk, .sdo_rdata, .sdo_ack, .sdo_abort, .sdo_write,
    .sdo_read, .sdo_index, .sdo_subindex, .sdo_wdata, .command_receive_message,
    .command_value);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic rdx(input logic [15:0] idx, input logic [7:0] sub);
    master.xfer(1'b0, idx, sub, 32'h0, rd, ab);
  endtask
  task automatic wrx(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d);
    master.xfer(1'b1, idx, sub, d, rd, ab);
  endtask
  // flash sequence as letters, one per rising lamp edge
  task automatic record(input int n);
    logic pr, py;
    s = "";
    for (int i = 0; i < n; i++) begin
      pr = red_lamp;
      py = yellow_lamp;
      @(negedge sys_clk);
      if (red_lamp && !pr) s = {s, "R"};
      if (yellow_lamp && !py) s = {s, "Y"};
    end
  endtask
  function automatic logic only(input byte c);
    only = s.len() >= 8;
    for (int i = 0; i < s.len(); i++) if (s[i] != c) only = 1'b0;
  endfunction
  task automatic t_monitor;
    for (int i = 0; i < 6; i++) begin
      current_samples[i*16 +: 16] = 16'h012C - 16'(i);
      duty_samples[i*16 +: 16] = 16'h03E8 - 16'(i);
    end
    temp_sample = 16'h0400;
    batt_sample = 16'h0123;
    rdx(`IDX_HEATSINK_TEMPERATURE, 8'h00);
    check("temperature high", rd, 32'h000003E8);
    rdx(`IDX_BATTERY_VOLTAGE, 8'h00);
    check("battery low", rd, 32'h00000123);
    temp_sample = 16'hFE00;
    batt_sample = 16'h0500;
    rdx(`IDX_HEATSINK_TEMPERATURE, 8'h00);
    check("temperature", rd, 32'hFFFFFE70);
    rdx(`IDX_BATTERY_VOLTAGE, 8'h00);
    check("battery", rd, 32'h000004B0);
    rdx(`IDX_OPERATING_HOURS, 8'h00);
    check("hours", rd, 32'h0000FFFF);
    rdx(`IDX_DRIVER_CURRENT_ARRAY, 8'h00);
    check("length", rd, 32'h00000006);
    for (int i = 1; i <= 6; i++) begin
      rdx(`IDX_DRIVER_CURRENT_ARRAY, 8'(i));
      check("current", rd, 32'h0000012D - 32'(i));
      rdx(`IDX_DRIVER_DUTY_ARRAY, 8'(i));
      check("duty", rd, 32'h000003E9 - 32'(i));
    end
    wrx(`IDX_DRIVER_DUTY_ARRAY, 8'h00, 32'h00000007);
    check("length write", ab, 1'b1);
    wrx(`IDX_BATTERY_VOLTAGE, 8'h00, 32'h00000010);
    check("monitor write", ab, 1'b0);
  endtask
  task automatic t_mode;
    master.send_command(16'h01F4);
    for (int m = 1; m <= 3; m++) begin
      wrx(`IDX_OUTPUT_CEILING, 8'h00, 32'h00000064);
      wrx(`IDX_OUTPUT_MODE, 8'h00, 32'(m));
      check("ceiling", output_ceiling, 32'h0);
      check("cleared", driver_command, 32'h0);
      check("unit", ceiling_unit, 32'(m));
      check("mode", output_mode, 32'(m));
      wrx(`IDX_OUTPUT_CEILING, 8'h00, 32'h00000050);
      check("ceiling set", output_ceiling, 32'h00000050);
      master.send_command(16'h0123);
      check("restored", driver_command, 32'h0123);
    end
  endtask
  task automatic t_nv;
    eeprom_fault_normal_set = 1'b1;
    eeprom_fault_backup_set = 1'b1;
    @(negedge sys_clk);
    eeprom_fault_normal_set = 1'b0;
    eeprom_fault_backup_set = 1'b0;
    wrx(`IDX_STORE_PARAMS, 8'h01, 32'h0);
    check("normal kept", eeprom_fault_normal, 1'b1);
    wrx(`IDX_FILTER_COEFF, 8'h01, 32'h00004000);
    check("normal clear", eeprom_fault_normal, 1'b0);
    check("backup kept", eeprom_fault_backup, 1'b1);
    wrx(`IDX_STORE_PARAMS, 8'h01, `BACKUP_COMMAND);
    check("backup clear", eeprom_fault_backup, 1'b0);
    wrx(`IDX_FILTER_COEFF, 8'h01, 32'h0);
    check("coeff low", ab, 1'b1);
    wrx(`IDX_FILTER_COEFF, 8'h02, 32'h00004001);
    check("coeff high", ab, 1'b1);
  endtask
  task automatic t_filter;
    wrx(`IDX_FILTER_COEFF, 8'h02, 32'h00002000);
    analog_samples = 32'h03E803E8;
    repeat (30) @(negedge sys_clk);
    check("one tc", 32'(analog_filtered[31:16] >= 16'd632), 32'h1);
    check("fast", 32'(analog_filtered[15:0] >= 16'd632), 32'h1);
    repeat (80) @(negedge sys_clk);
    check("five tc", 32'(analog_filtered[31:16] >= 16'd990), 32'h1);
  endtask
  task automatic t_fault;
    hours_sample = 16'h1234;
    @(negedge sys_clk);
    fault_code = 8'h23;
    @(negedge sys_clk);
    check("emcy", {emcy_send, emcy_code}, 32'h123);
    check("logged", log_count, 32'h1);
    record(5);
    check("no repeat", emcy_send, 1'b0);
    check("log entry", log_read_data, 32'h231234);
    fault_code = 8'h00;
    @(negedge sys_clk);
    check("no fault emcy", {emcy_send, emcy_code}, 32'h100);
    for (int i = 0; i < 20; i++) begin
      fault_code = i[0] ? 8'h41 : 8'h31;
      @(negedge sys_clk);
    end
    check("log full", log_count, 32'h10);
    log_read_index = 4'h1;
    @(negedge sys_clk);
    check("log overwrite", log_read_data, 32'h311234);
    fault_code = 8'h23;
    record(300);
    ab = 1'b1;
    for (int i = 0; i + 8 <= s.len(); i++) if (s.substr(i, i + 7) == "RYYRRYYY") ab = 1'b0;
    check("flash order", ab, 1'b0);
  endtask
  initial begin
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    record(100);
    check("idle yellow", only(8'h59), 1'b1);
    t_monitor();
    t_mode();
    t_nv();
    t_filter();
    t_fault();
    fault_code = 8'h00;
    code_check_done = 1'b0;
    rst = 1'b1;
    repeat (20) @(negedge sys_clk);
    rst = 1'b0;
    code_check_ok = 1'b0;
    code_check_done = 1'b1;
    record(60);
    check("fast red", only(8'h52), 1'b1);
    print_verdict();
  end
endmodule
`default_nettype wire
